// ==== inc/iic_pkg.sv ====
// Purpose: Shared constants for the isolated input channel output logic.
// Assumes: core_clk at 20 MHz, registers eight bits wide on a plain port.
// Notes: Long delay counts live as parameters of the top module.

package iic_pkg;

	localparam int NUM_CH = 8;
	localparam int CNT_W = 22;

	// Timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int LP_FIXED_NS = 4000;
	localparam int LP_FIXED_CYC = (LP_FIXED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NS_PER_MS = 1000000;
	localparam int DLY_A_MS = 10;
	localparam int DLY_B_MS = 30;
	localparam int DLY_C_MS = 100;
	localparam int STARTUP_US = 40;
	localparam int STARTUP_CYC = (STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Register offsets
	localparam logic [7:0] REG_CHAN_STATE = 8'h00;
	localparam logic [7:0] REG_FILT_MODE0 = 8'h01;
	localparam logic [7:0] REG_FILT_MODE1 = 8'h02;
	localparam logic [7:0] REG_FILT_DLY0 = 8'h03;
	localparam logic [7:0] REG_FILT_DLY1 = 8'h04;

	// Reset values
	localparam logic [7:0] FILT_MODE_RST = 8'h00;
	localparam logic [7:0] FILT_DLY_RST = 8'h00;

	// Field layout: two bits per channel, four channels per register
	localparam int FIELD_W = 2;
	localparam int CH_PER_REG = 4;

	// Mode field encoding
	localparam logic [1:0] MODE_LOWPASS = 2'h0;
	localparam logic [1:0] MODE_DEGLITCH = 2'h1;
	localparam logic [1:0] MODE_BLANKING = 2'h2;

	// Delay field encoding
	localparam logic [1:0] DLY_NONE = 2'h0;
	localparam logic [1:0] DLY_A = 2'h1;
	localparam logic [1:0] DLY_B = 2'h2;
	localparam logic [1:0] DLY_C = 2'h3;

	typedef enum logic [1:0] {
		SUP_LOCKOUT,
		SUP_WAIT,
		SUP_ACTIVE
	} iic_sup_state_t;

endpackage

// ==== verilog/iic_sync.sv ====
// Purpose: Two-stage synchroniser for pin inputs.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second.

`timescale 1ns/1ps

module iic_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_r <= '0;
			sync_out <= '0;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule // iic_sync

// ==== verilog/iic_hold_filter.sv ====
// Purpose: Output follows input only after it held a new level for hold_cyc cycles.
// Assumes: hold_cyc of zero means pass-through with one cycle of register delay.
// Notes: Any return to the old level restarts the count.

`timescale 1ns/1ps

module iic_hold_filter (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Control
	input wire logic clear,
	input wire logic [iic_pkg::CNT_W-1:0] hold_cyc,
	// Data
	input wire logic din,
	output logic dout
);

	logic [iic_pkg::CNT_W-1:0] cnt_r;
	logic [iic_pkg::CNT_W-1:0] cnt_inc;
	logic expired;

	assign cnt_inc = cnt_r + 1'b1;
	assign expired = (hold_cyc == '0) || (cnt_inc >= hold_cyc);

	always_ff @(posedge core_clk) begin
		if (reset || clear) begin
			cnt_r <= '0;
			dout <= 1'b0;
		end else if (din == dout) begin
			cnt_r <= '0;
		end else if (expired) begin
			cnt_r <= '0;
			dout <= din;
		end else begin
			cnt_r <= cnt_inc;
		end
	end

endmodule // iic_hold_filter

// ==== verilog/iic_top.sv ====
// Purpose: Output-side logic of eight isolated input channels with debounce and lockout.
// Assumes: field_input and supply comparator pins are asynchronous to core_clk.
// Notes: Variant straps are taken while reset is high and held until the next reset.

`timescale 1ns/1ps

module iic_top #(
	parameter int DLY_A_CYC = iic_pkg::DLY_A_MS * (iic_pkg::NS_PER_MS / iic_pkg::CLK_PERIOD_NS),
	parameter int DLY_B_CYC = iic_pkg::DLY_B_MS * (iic_pkg::NS_PER_MS / iic_pkg::CLK_PERIOD_NS),
	parameter int DLY_C_CYC = iic_pkg::DLY_C_MS * (iic_pkg::NS_PER_MS / iic_pkg::CLK_PERIOD_NS)
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Field side, after isolation
	input wire logic [7:0] field_input,
	// Supply comparators
	input wire logic supply_below_fall,
	input wire logic supply_above_rise,
	// Variant straps
	input wire logic strap_serial,
	input wire logic [1:0] strap_delay,
	input wire logic [1:0] strap_fast_count,
	// Channel outputs
	output logic [7:0] fast_output,
	output logic [7:0] filtered_output,
	// Cascade
	input wire logic serial_data_in,
	output logic serial_passthrough_out,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Status
	output logic outputs_live
);

	localparam int N = iic_pkg::NUM_CH;
	localparam int W = iic_pkg::CNT_W;

	// Delay field to cycle count
	function automatic logic [W-1:0] dly_cycles(input logic [1:0] sel);
		logic [W-1:0] c;
		c = '0;
		case (sel)
			iic_pkg::DLY_A: c = W'(DLY_A_CYC);
			iic_pkg::DLY_B: c = W'(DLY_B_CYC);
			iic_pkg::DLY_C: c = W'(DLY_C_CYC);
			default: c = '0;
		endcase
		return c;
	endfunction

	// Two-bit field of channel ch out of a pair of packed registers
	function automatic logic [1:0] ch_field(input logic [7:0] lo, input logic [7:0] hi,
		input int ch);
		logic [7:0] r;
		int pos;
		r = (ch < iic_pkg::CH_PER_REG) ? lo : hi;
		pos = (ch % iic_pkg::CH_PER_REG) * iic_pkg::FIELD_W;
		return r[pos+:2];
	endfunction

	// Synchronised pins
	logic [7:0] field_sync;
	logic [1:0] supply_sync;
	logic [5:0] strap_sync;
	logic pass_sync;

	iic_sync #(.WIDTH(8)) u_sync_field (
		.core_clk(core_clk),
		.reset(reset),
		.async_in(field_input),
		.sync_out(field_sync)
	);

	iic_sync #(.WIDTH(2)) u_sync_supply (
		.core_clk(core_clk),
		.reset(reset),
		.async_in({supply_above_rise, supply_below_fall}),
		.sync_out(supply_sync)
	);

	// Cascade path does not gate on reset of the straps
	iic_sync #(.WIDTH(7)) u_sync_misc (
		.core_clk(core_clk),
		.reset(1'b0),
		.async_in({serial_data_in, strap_fast_count, strap_delay, strap_serial, 1'b0}),
		.sync_out({pass_sync, strap_sync})
	);

	wire supply_low = supply_sync[0];
	wire supply_high = supply_sync[1];

	// Variant straps, sampled throughout reset
	logic serial_r;
	logic [1:0] var_delay_r;
	logic [1:0] fast_count_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			serial_r <= strap_sync[1];
			var_delay_r <= strap_sync[3:2];
			fast_count_r <= strap_sync[5:4];
		end
	end

	// Fast channels are the lowest-numbered ones; the serial variant has none
	wire [3:0] fast_num = serial_r ? 4'h0 : (4'h1 << fast_count_r) & 4'hE;
	logic [7:0] fast_mask;
	always_comb begin
		for (int i = 0; i < N; i++) begin
			fast_mask[i] = (4'(i) < fast_num);
		end
	end

	// Supply lockout sequencer
	iic_pkg::iic_sup_state_t sup_r, sup_nxt;
	logic [W-1:0] start_cnt_r, start_cnt_nxt;
	logic clear_path;

	always_comb begin
		sup_nxt = sup_r;
		start_cnt_nxt = start_cnt_r;
		case (sup_r)
			iic_pkg::SUP_LOCKOUT: begin
				start_cnt_nxt = '0;
				if (supply_high && !supply_low) begin
					sup_nxt = iic_pkg::SUP_WAIT;
				end
			end
			iic_pkg::SUP_WAIT: begin
				if (supply_low) begin
					sup_nxt = iic_pkg::SUP_LOCKOUT;
				end else if (start_cnt_r + 1'b1 >= W'(iic_pkg::STARTUP_CYC)) begin
					sup_nxt = iic_pkg::SUP_ACTIVE;
				end else begin
					start_cnt_nxt = start_cnt_r + 1'b1;
				end
			end
			iic_pkg::SUP_ACTIVE: begin
				if (supply_low) begin
					sup_nxt = iic_pkg::SUP_LOCKOUT;
				end
			end
			default: sup_nxt = iic_pkg::SUP_LOCKOUT;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sup_r <= iic_pkg::SUP_LOCKOUT;
			start_cnt_r <= '0;
		end else begin
			sup_r <= sup_nxt;
			start_cnt_r <= start_cnt_nxt;
		end
	end

	// Filters stay cleared outside the active state so they start from low
	assign clear_path = (sup_r != iic_pkg::SUP_ACTIVE);

	// Configuration registers
	logic [7:0] mode_lo_r, mode_hi_r, dly_lo_r, dly_hi_r;

	wire wr_mode_lo = reg_wr && (reg_addr == iic_pkg::REG_FILT_MODE0);
	wire wr_mode_hi = reg_wr && (reg_addr == iic_pkg::REG_FILT_MODE1);
	wire wr_dly_lo = reg_wr && (reg_addr == iic_pkg::REG_FILT_DLY0);
	wire wr_dly_hi = reg_wr && (reg_addr == iic_pkg::REG_FILT_DLY1);

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_lo_r <= iic_pkg::FILT_MODE_RST;
			mode_hi_r <= iic_pkg::FILT_MODE_RST;
			dly_lo_r <= iic_pkg::FILT_DLY_RST;
			dly_hi_r <= iic_pkg::FILT_DLY_RST;
		end else begin
			if (wr_mode_lo) mode_lo_r <= reg_wdata;
			if (wr_mode_hi) mode_hi_r <= reg_wdata;
			if (wr_dly_lo) dly_lo_r <= reg_wdata;
			if (wr_dly_hi) dly_hi_r <= reg_wdata;
		end
	end

	// Per-channel slow path
	logic [7:0] lp_fixed;
	logic [7:0] lp_mode_out;
	logic [7:0] deg_out_r;
	logic [7:0] blank_out_r;
	logic [7:0] slow_out;

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			logic [1:0] mode_sel;
			logic [1:0] dly_sel;
			logic [W-1:0] dly_cyc;
			logic [W-1:0] deg_cnt_r;
			logic [W-1:0] blank_cnt_r;
			logic [W-1:0] deg_inc;

			// Parallel variants run low-pass only, one strapped delay for all
			assign mode_sel = serial_r ? ch_field(mode_lo_r, mode_hi_r, g)
				: iic_pkg::MODE_LOWPASS;
			assign dly_sel = serial_r ? ch_field(dly_lo_r, dly_hi_r, g)
				: var_delay_r;
			assign dly_cyc = dly_cycles(dly_sel);
			assign deg_inc = deg_cnt_r + 1'b1;

			// Fixed stage precedes every mode
			iic_hold_filter u_fixed (
				.core_clk(core_clk),
				.reset(reset),
				.clear(clear_path),
				.hold_cyc(W'(iic_pkg::LP_FIXED_CYC)),
				.din(field_sync[g]),
				.dout(lp_fixed[g])
			);

			iic_hold_filter u_lowpass (
				.core_clk(core_clk),
				.reset(reset),
				.clear(clear_path),
				.hold_cyc(dly_cyc),
				.din(lp_fixed[g]),
				.dout(lp_mode_out[g])
			);

			// Deglitch: integrating counter, short glitches only wind it up and it counts back down after
			always_ff @(posedge core_clk) begin
				if (reset || clear_path) begin
					deg_cnt_r <= '0;
					deg_out_r[g] <= 1'b0;
				end else if (lp_fixed[g] != deg_out_r[g]) begin
					if (dly_cyc == '0 || deg_inc >= dly_cyc) begin
						deg_out_r[g] <= lp_fixed[g];
						deg_cnt_r <= '0;
					end else begin
						deg_cnt_r <= deg_inc;
					end
				end else if (deg_cnt_r != '0) begin
					deg_cnt_r <= deg_cnt_r - 1'b1;
				end
			end

			// Blanking: follow the first edge, then ignore the input for the delay
			always_ff @(posedge core_clk) begin
				if (reset || clear_path) begin
					blank_cnt_r <= '0;
					blank_out_r[g] <= 1'b0;
				end else if (blank_cnt_r != '0) begin
					blank_cnt_r <= blank_cnt_r - 1'b1;
				end else if (lp_fixed[g] != blank_out_r[g]) begin
					blank_out_r[g] <= lp_fixed[g];
					blank_cnt_r <= dly_cyc;
				end
			end

			// Reserved code falls back to low-pass
			always_comb begin
				case (mode_sel)
					iic_pkg::MODE_DEGLITCH: slow_out[g] = deg_out_r[g];
					iic_pkg::MODE_BLANKING: slow_out[g] = blank_out_r[g];
					default: slow_out[g] = lp_mode_out[g];
				endcase
			end
		end
	endgenerate

	// Output stage; lockout holds outputs low rather than undefined
	always_ff @(posedge core_clk) begin
		if (reset || clear_path) begin
			fast_output <= 8'h00;
			filtered_output <= 8'h00;
			outputs_live <= 1'b0;
		end else begin
			fast_output <= field_sync & fast_mask;
			filtered_output <= slow_out & ~fast_mask;
			outputs_live <= 1'b1;
		end
	end

	// Cascade copy of the serial input
	always_ff @(posedge core_clk) begin
		if (reset) begin
			serial_passthrough_out <= 1'b0;
		end else begin
			serial_passthrough_out <= serial_r & pass_sync;
		end
	end

	// Register read port, data one cycle after the strobe
	logic [7:0] rd_mux;
	always_comb begin
		case (reg_addr)
			iic_pkg::REG_CHAN_STATE: rd_mux = fast_output | filtered_output;
			iic_pkg::REG_FILT_MODE0: rd_mux = mode_lo_r;
			iic_pkg::REG_FILT_MODE1: rd_mux = mode_hi_r;
			iic_pkg::REG_FILT_DLY0: rd_mux = dly_lo_r;
			iic_pkg::REG_FILT_DLY1: rd_mux = dly_hi_r;
			default: rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			reg_rdata <= rd_mux;
		end else begin
			reg_rdata <= 8'h00;
		end
	end

endmodule // iic_top

// ==== testbench/iic_top_props.sv ====
// Purpose: Port-level checks of the channel output logic.
// Assumes: Straps are held steady outside reset.
// Notes: Startup window counted from the raw supply pins, so it allows for the syncs.
`timescale 1ns/1ps
module iic_top_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// Inputs watched
	input wire logic [7:0] field_input,
	input wire logic supply_below_fall,
	input wire logic supply_above_rise,
	input wire logic strap_serial,
	input wire logic serial_data_in,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	// Outputs watched
	input wire logic [7:0] fast_output,
	input wire logic [7:0] filtered_output,
	input wire logic serial_passthrough_out,
	input wire logic [7:0] reg_rdata,
	input wire logic outputs_live
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	logic [11:0] ok_cnt_r;
	always_ff @(posedge core_clk) begin
		if (reset || supply_below_fall || (ok_cnt_r == 12'h000 && !supply_above_rise))
			ok_cnt_r <= 12'h000;
		else if (ok_cnt_r != 12'hFFF)
			ok_cnt_r <= ok_cnt_r + 12'h001;
	end
	sequence cfg_write_s;
		reg_wr && reg_addr inside {[8'h01:8'h04]};
	endsequence
	sequence same_read_s;
		reg_rd && reg_addr == $past(reg_addr);
	endsequence
	out_split_a: assert property ((fast_output & filtered_output) == 8'h00)
		else $error("fast and filtered outputs overlap");
	fast_cause_a: assert property (outputs_live && $past(outputs_live, 4) |->
		(fast_output & ~($past(field_input, 2) | $past(field_input, 3)
		| $past(field_input, 4))) == 8'h00) else $error("fast output high without input");
	lock_quiet_a: assert property ($past(!outputs_live) && !outputs_live |->
		(fast_output | filtered_output) == 8'h00) else $error("outputs moved in lockout");
	start_wait_a: assert property ($rose(outputs_live) |->
		ok_cnt_r >= iic_pkg::STARTUP_CYC && ok_cnt_r <= iic_pkg::STARTUP_CYC + 8)
		else $error("startup wait length wrong");
	live_drop_a: assert property (supply_below_fall |-> ##[1:5] !outputs_live)
		else $error("lockout not entered");
	rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside read answer");
	cfg_echo_a: assert property (cfg_write_s ##1 same_read_s |=>
		reg_rdata == $past(reg_wdata, 2)) else $error("config readback wrong");
	unmapped_a: assert property (reg_rd && reg_addr > 8'h04 |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	thru_copy_a: assert property ($past(!reset, 3) |->
		serial_passthrough_out == (strap_serial && $past(serial_data_in, 3)))
		else $error("cascade output wrong");
endmodule // iic_top_props

bind iic_top iic_top_props i_props (
	.core_clk(core_clk),
	.reset(reset),
	.field_input(field_input),
	.supply_below_fall(supply_below_fall),
	.supply_above_rise(supply_above_rise),
	.strap_serial(strap_serial),
	.serial_data_in(serial_data_in),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_wr(reg_wr),
	.reg_rd(reg_rd),
	.fast_output(fast_output),
	.filtered_output(filtered_output),
	.serial_passthrough_out(serial_passthrough_out),
	.reg_rdata(reg_rdata),
	.outputs_live(outputs_live)
);

// ==== testbench/iic_host_model.sv ====
// Purpose: Host that reads the channel outputs as levels.
// Assumes: Fast and slow outputs share one wire per channel at the host.
// Notes: Counts level changes so short pulses that leak through are seen.
`timescale 1ns/1ps
module iic_host_model (
	// Clock
	input wire logic core_clk,
	// Channel outputs
	input wire logic [7:0] fast_output,
	input wire logic [7:0] filtered_output,
	// What the host sees
	output logic [7:0] levels,
	output logic [7:0] edges
);
	logic [7:0] last_r = 8'h00;
	initial edges = 8'h00;
	assign levels = fast_output | filtered_output;
	always @(posedge core_clk) begin
		last_r <= levels;
		if (levels != last_r)
			edges <= edges + 8'h01;
	end
endmodule // iic_host_model

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench for the channel output logic.
// Assumes: Short debounce counts so the long delays fit in one run.
// Notes: Straps change only while reset is high.
`timescale 1ns/1ps
module tb_top;
	localparam int DA = 20;
	localparam int DB = 60;
	localparam int DC = 200;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] field_input = 8'h00;
	logic supply_below_fall = 1'b1;
	logic supply_above_rise = 1'b0;
	logic strap_serial = 1'b1;
	logic [1:0] strap_delay = 2'h0;
	logic [1:0] strap_fast_count = 2'h0;
	logic serial_data_in = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] fast_output, filtered_output, reg_rdata, levels, edges;
	logic serial_passthrough_out, outputs_live;
	int n_fail = 0;
	int comparisons = 0;
	int lat[8];
	always #25 core_clk = ~core_clk;
	iic_top #(.DLY_A_CYC(DA), .DLY_B_CYC(DB), .DLY_C_CYC(DC)) i_dut (
		.core_clk(core_clk), .reset(reset), .field_input(field_input),
		.supply_below_fall(supply_below_fall), .supply_above_rise(supply_above_rise),
		.strap_serial(strap_serial), .strap_delay(strap_delay),
		.strap_fast_count(strap_fast_count), .fast_output(fast_output),
		.filtered_output(filtered_output), .serial_data_in(serial_data_in),
		.serial_passthrough_out(serial_passthrough_out), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .outputs_live(outputs_live));
	iic_host_model i_host (.core_clk(core_clk), .fast_output(fast_output),
		.filtered_output(filtered_output), .levels(levels), .edges(edges));
	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		comparisons++;
		if (g < lo || g > hi) begin
			n_fail++;
			$display("FAIL %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask
	// Read data stands only in the cycle after the strobe, so it is taken mid-cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] got;
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		got = reg_rdata;
		@(posedge core_clk);
		chk("reg_rdata", e, got);
	endtask
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		rd(a, e);
	endtask
	function automatic int dly_cyc(input logic [1:0] c);
		if (c == iic_pkg::DLY_A) return DA;
		if (c == iic_pkg::DLY_B) return DB;
		if (c == iic_pkg::DLY_C) return DC;
		return 0;
	endfunction
	task automatic meas(input logic [7:0] v);
		field_input <= v;
		foreach (lat[c]) lat[c] = -1;
		for (int i = 0; i < 400; i++) begin
			@(negedge core_clk);
			foreach (lat[c]) if (lat[c] < 0 && levels[c] === v[c]) lat[c] = i;
		end
		@(posedge core_clk);
	endtask
	task automatic chk_lat(input logic [7:0] fast, input logic [15:0] codes);
		int lo;
		foreach (lat[c]) begin
			lo = fast[c] ? 2 : iic_pkg::LP_FIXED_CYC + dly_cyc(codes[2*c +: 2]);
			chk_rng("channel latency", lo, lo + (fast[c] ? 2 : 8), lat[c]);
		end
	endtask
	task automatic do_reset(input logic s, input logic [1:0] d, input logic [1:0] f);
		reset <= 1'b1;
		strap_serial <= s;
		strap_delay <= d;
		strap_fast_count <= f;
		supply_below_fall <= 1'b1;
		supply_above_rise <= 1'b0;
		field_input <= 8'h00;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic supply_up();
		int n;
		supply_below_fall <= 1'b0;
		supply_above_rise <= 1'b1;
		n = 0;
		while (outputs_live !== 1'b1 && n < 2000) begin
			@(negedge core_clk);
			n++;
		end
		chk_rng("startup cycles", iic_pkg::STARTUP_CYC, iic_pkg::STARTUP_CYC + 8, n);
		chk("levels at start", 8'h00, levels);
		@(posedge core_clk);
	endtask
	initial begin
		logic [7:0] d;
		logic [1:0] md;
		logic [3:0] h;
		void'($urandom(34202));
		do_reset(1'b1, 2'h0, 2'h0);
		supply_up();
		for (int a = 1; a <= 4; a++) rd(8'(a), 8'h00);
		for (int a = 1; a <= 4; a++) begin
			d = 8'($urandom);
			wr_rd(8'(a), d, d);
		end
		wr_rd(8'h00, 8'($urandom), 8'h00);
		wr_rd(8'h05 + 8'($urandom % 250), 8'hA5, 8'h00);
		wr_rd(8'h03, 8'h00, 8'h00);
		wr_rd(8'h04, 8'h00, 8'h00);
		// Code 3 is reserved and must behave as low-pass
		for (int m = 0; m < 4; m++) begin
			md = 2'(m);
			wr_rd(8'h01, {4{md}}, {4{md}});
			wr_rd(8'h02, {4{md}}, {4{md}});
			meas(8'hFF);
			chk_lat(8'h00, 16'h0000);
			meas(8'h00);
			chk_lat(8'h00, 16'h0000);
		end
		wr_rd(8'h01, 8'h00, 8'h00);
		wr_rd(8'h02, 8'h00, 8'h00);
		wr_rd(8'h03, 8'hE4, 8'hE4);
		wr_rd(8'h04, 8'h1B, 8'h1B);
		meas(8'hFF);
		chk_lat(8'h00, 16'h1BE4);
		meas(8'h00);
		chk_lat(8'h00, 16'h1BE4);
		d = edges;
		field_input <= 8'hFF;
		repeat (iic_pkg::LP_FIXED_CYC - 20) @(posedge core_clk);
		field_input <= 8'h00;
		repeat (150) @(posedge core_clk);
		@(negedge core_clk);
		chk("edges after short pulse", d, edges);
		@(posedge core_clk);
		h = 4'h0;
		repeat (40) begin
			md[0] = 1'($urandom);
			serial_data_in <= md[0];
			h = {h[2:0], md[0]};
			@(negedge core_clk);
			chk("cascade output", {7'h00, h[3]}, {7'h00, serial_passthrough_out});
			@(posedge core_clk);
		end
		field_input <= 8'hFF;
		repeat (300) @(posedge core_clk);
		supply_below_fall <= 1'b1;
		supply_above_rise <= 1'b0;
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		chk("levels in lockout", 8'h00, levels);
		@(posedge core_clk);
		supply_below_fall <= 1'b0;
		repeat (1000) @(posedge core_clk);
		@(negedge core_clk);
		chk("live in band", 8'h00, {7'h00, outputs_live});
		@(posedge core_clk);
		supply_up();
		repeat (300) @(posedge core_clk);
		rd(8'h00, 8'hFF);
		do_reset(1'b0, iic_pkg::DLY_A, 2'h2);
		serial_data_in <= 1'b1;
		supply_up();
		wr_rd(8'h01, 8'hAA, 8'hAA);
		wr_rd(8'h04, 8'hFF, 8'hFF);
		meas(8'hFF);
		chk_lat(8'h0F, {8{iic_pkg::DLY_A}});
		@(negedge core_clk);
		chk("cascade parallel", 8'h00, {7'h00, serial_passthrough_out});
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		n_fail++;
		$display("FAIL watchdog expected finish seen timeout");
		wrap_up();
	end
endmodule // tb_top
